// ==== common/slbc_pkg.sv ====
// Constants and types for the strap latch and boot configuration block.
// Assumes a 100 MHz clk; times are given in microseconds.
package slbc_pkg;

  localparam int unsigned CLK_MHZ       = 100;
  // Power-up pin low time that counts as a chip reset, in microseconds
  localparam int unsigned PU_RESET_US   = 50;
  localparam int unsigned PU_RESET_CYC  = PU_RESET_US * CLK_MHZ;
  // Rail settle time before the power-up pin rises, in microseconds
  localparam int unsigned SETTLE_US     = 50;
  localparam int unsigned SETTLE_CYC    = SETTLE_US * CLK_MHZ;
  // Cycles the straps are sampled after power-up rises (hold window)
  localparam int unsigned HOLD_CYC      = 4;

  // Register map of the plain port
  localparam logic [3:0] OFF_STATUS     = 4'h0;
  localparam logic [3:0] OFF_LATCH      = 4'h4;
  localparam logic [3:0] OFF_PRINT_CTL  = 4'h8;
  localparam logic [3:0] OFF_FUSE       = 4'hC;

  // Field positions
  localparam int unsigned F_STRAP_A     = 0;
  localparam int unsigned F_PRINT       = 1;
  localparam int unsigned F_VOLT        = 2;
  localparam int unsigned F_DBG         = 3;
  localparam int unsigned F_UART_DIS    = 0;
  localparam int unsigned F_USB_DIS     = 1;

  // Pull defaults loaded into the strap latches at reset, and the print control reset value
  localparam logic STRAP_A_PULL         = 1'b1;
  localparam logic VOLT_PULL            = 1'b0;
  localparam logic PRINT_PULL           = 1'b0;
  localparam logic [1:0] PRINT_CTL_RST  = 2'h0;

  typedef enum logic [1:0] {
    SLBC_BOOT_SPI,
    SLBC_BOOT_DOWNLOAD,
    SLBC_BOOT_INVALID
  } slbc_boot_t;

  typedef enum logic {
    SLBC_VOLT_3V3,
    SLBC_VOLT_1V8
  } slbc_volt_t;

  typedef enum logic [1:0] {
    SLBC_DBG_USB,
    SLBC_DBG_PAD,
    SLBC_DBG_OFF
  } slbc_dbg_t;

endpackage

// ==== core/slbc_sync.sv ====
// Two-stage synchroniser for a bundle of pin levels.
// Assumes the inputs change asynchronously to clk.
`timescale 1ns/1ps
`default_nettype none
module slbc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ==== core/slbc_top.sv ====
// Strap latch and boot configuration decoder with a plain register port.
// Assumes strap and power-up pins are asynchronous; fuses are static.
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module slbc_top
  import slbc_pkg::*;
#(
  parameter int unsigned PU_CYC = PU_RESET_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        power_up_pin,
  input  wire logic        boot_strap_a_i,
  input  wire logic        boot_print_strap_i,
  input  wire logic        flash_volt_strap_i,
  input  wire logic        debug_src_strap_i,
  input  wire logic        flash_volt_force_fuse,
  input  wire logic        flash_volt_level_fuse,
  input  wire logic        pad_debug_disable_fuse,
  input  wire logic        usb_debug_disable_fuse,
  input  wire logic        debug_strap_enable_fuse,
  input  wire logic        uart_print_disable_fuse,
  input  wire logic        usb_print_disable_fuse,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             chip_en_q,
  output logic             straps_released_q,
  output logic             pull_up_en_n_q,
  output logic             pull_down_en_n_q,
  output slbc_boot_t       boot_mode_q,
  output slbc_volt_t       flash_volt_q,
  output logic             print_uart_en_q,
  output logic             print_usb_en_q,
  output slbc_dbg_t        debug_src_q
);

  localparam int unsigned CW = $clog2(PU_CYC + 1);

  typedef enum logic [1:0] {
    SLBC_OFF,
    SLBC_SAMPLE,
    SLBC_RUN
  } slbc_state_t;

  logic [4:0]     pins_s;
  logic           pu_s;
  logic [CW-1:0]  low_cnt_q;
  logic [2:0]     hold_q;
  slbc_state_t    st_q;
  logic [3:0]     latch_q;
  logic [1:0]     print_ctl_q;
  logic           pu_low_long;

  function automatic slbc_boot_t boot_dec(input logic a, input logic p);
    if (a)
      boot_dec = SLBC_BOOT_SPI;
    else if (!p)
      boot_dec = SLBC_BOOT_DOWNLOAD;
    else
      boot_dec = SLBC_BOOT_INVALID;
  endfunction

  function automatic slbc_volt_t volt_dec(input logic force_f,
                                          input logic lvl_f,
                                          input logic strap);
    if (!force_f)
      volt_dec = strap ? SLBC_VOLT_1V8 : SLBC_VOLT_3V3;
    else
      volt_dec = lvl_f ? SLBC_VOLT_3V3 : SLBC_VOLT_1V8;
  endfunction

  function automatic slbc_dbg_t dbg_dec(input logic pad_dis,
                                        input logic usb_dis,
                                        input logic sel_en,
                                        input logic strap);
    case ({pad_dis, usb_dis})
      2'b00:   dbg_dec = (sel_en && !strap) ? SLBC_DBG_PAD
                                            : SLBC_DBG_USB;
      2'b01:   dbg_dec = SLBC_DBG_PAD;
      2'b10:   dbg_dec = SLBC_DBG_USB;
      default: dbg_dec = SLBC_DBG_OFF;
    endcase
  endfunction

  // Pins pass two flops before use
  slbc_sync #(.W(5)) u_sync (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .d   ({power_up_pin, debug_src_strap_i, flash_volt_strap_i,
           boot_print_strap_i, boot_strap_a_i}),
    .q   (pins_s)
  );

  assign pu_s        = pins_s[4];
  assign pu_low_long = (low_cnt_q >= CW'(PU_CYC));

  // Low time of the power-up pin
  always_ff @(posedge clk) begin
    if (rst) begin
      low_cnt_q <= '0;
    end else if (ce) begin
      if (pu_s)
        low_cnt_q <= '0;
      else if (!pu_low_long)
        low_cnt_q <= low_cnt_q + CW'(1);
    end
  end

  // Power and sampling sequence
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q   <= SLBC_OFF;
      hold_q <= '0;
    end else if (ce) begin
      case (st_q)
        SLBC_OFF: begin
          hold_q <= '0;
          if (pu_s)
            st_q <= SLBC_SAMPLE;
        end
        SLBC_SAMPLE: begin
          hold_q <= hold_q + 3'h1;
          if (!pu_s)
            st_q <= SLBC_OFF;
          else if (hold_q == 3'(HOLD_CYC - 1))
            st_q <= SLBC_RUN;
        end
        SLBC_RUN: begin
          if (pu_low_long)
            st_q <= SLBC_OFF;
        end
        default: st_q <= SLBC_OFF;
      endcase
    end
  end

  // Strap latches, written only while sampling
  always_ff @(posedge clk) begin
    if (rst) begin
      latch_q <= {1'b0, VOLT_PULL, PRINT_PULL, STRAP_A_PULL};
    end else if (ce && st_q == SLBC_SAMPLE) begin
      latch_q <= pins_s[3:0];
    end
  end

  // Pad control: pulls on until the straps are released
  always_ff @(posedge clk) begin
    if (rst) begin
      chip_en_q         <= 1'b0;
      straps_released_q <= 1'b0;
      pull_up_en_n_q    <= 1'b0;
      pull_down_en_n_q  <= 1'b0;
    end else if (ce) begin
      chip_en_q         <= (st_q != SLBC_OFF);
      straps_released_q <= (st_q == SLBC_RUN);
      pull_up_en_n_q    <= (st_q == SLBC_RUN);
      pull_down_en_n_q  <= (st_q == SLBC_RUN);
    end
  end

  // Decoded selections; one edge into RUN sees the last latch write
  always_ff @(posedge clk) begin
    if (rst) begin
      boot_mode_q  <= SLBC_BOOT_SPI;
      flash_volt_q <= SLBC_VOLT_3V3;
      debug_src_q  <= SLBC_DBG_USB;
    end else if (ce && !straps_released_q) begin
      boot_mode_q  <= boot_dec(latch_q[F_STRAP_A],
                               latch_q[F_PRINT]);
      flash_volt_q <= volt_dec(flash_volt_force_fuse,
                               flash_volt_level_fuse,
                               latch_q[F_VOLT]);
      debug_src_q  <= dbg_dec(pad_debug_disable_fuse,
                              usb_debug_disable_fuse,
                              debug_strap_enable_fuse,
                              latch_q[F_DBG]);
    end
  end

  // Message routing control register
  always_ff @(posedge clk) begin
    if (rst) begin
      print_ctl_q <= PRINT_CTL_RST;
    end else if (ce && reg_wr && reg_addr == OFF_PRINT_CTL) begin
      print_ctl_q <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      print_uart_en_q <= 1'b0;
      print_usb_en_q  <= 1'b0;
    end else if (ce) begin
      print_uart_en_q <= !print_ctl_q[F_UART_DIS] &&
                         !uart_print_disable_fuse;
      print_usb_en_q  <= !print_ctl_q[F_USB_DIS] &&
                         !usb_print_disable_fuse;
    end
  end

  // Read port, data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (ce) begin
      reg_rdata <= '0;
      if (reg_rd) begin
        case (reg_addr)
          OFF_STATUS: reg_rdata <= {25'h0, debug_src_q, flash_volt_q,
                                    boot_mode_q, straps_released_q,
                                    chip_en_q};
          OFF_LATCH:     reg_rdata <= {28'h0, latch_q};
          OFF_PRINT_CTL: reg_rdata <= {30'h0, print_ctl_q};
          OFF_FUSE:      reg_rdata <= {27'h0, debug_strap_enable_fuse,
                                       usb_debug_disable_fuse,
                                       pad_debug_disable_fuse,
                                       flash_volt_level_fuse,
                                       flash_volt_force_fuse};
          default:       reg_rdata <= '0;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ==== testbench/slbc_board.sv ====
// Board model driving the four strap pins.
// Undriven straps follow the chip pulls, else float and wander.
`timescale 1ns/1ps
`default_nettype none
module slbc_board (
  input  wire logic       clk,
  input  wire logic       pull_up_en_n_q,
  input  wire logic       pull_down_en_n_q,
  input  wire logic       drv_en,
  input  wire logic [3:0] drv_val,
  output logic            boot_strap_a_i,
  output logic            boot_print_strap_i,
  output logic            flash_volt_strap_i,
  output logic            debug_src_strap_i
);
  logic tgl = 1'h0;
  always @(posedge clk) tgl <= ~tgl;
  assign boot_strap_a_i = drv_en ? drv_val[0] : pull_up_en_n_q ? tgl : 1'h1;
  assign boot_print_strap_i = drv_en ? drv_val[1] : pull_down_en_n_q ? tgl : 1'h0;
  assign flash_volt_strap_i = drv_en ? drv_val[2] : pull_down_en_n_q ? tgl : 1'h0;
  // No pull here, so the board always drives it
  assign debug_src_strap_i = drv_val[3];
endmodule
`default_nettype wire

// ==== testbench/slbc_top_monitor.sv ====
// Checker for slbc_top: release, freeze and fuse decode.
// Fuses are held static while the straps stay released.
`timescale 1ns/1ps
`default_nettype none
module slbc_top_monitor
  import slbc_pkg::*;
#(
  parameter int unsigned PU_CYC = 20
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        chip_en_q,
  input wire logic        straps_released_q,
  input wire logic        pull_up_en_n_q,
  input wire logic        pull_down_en_n_q,
  input wire logic        flash_volt_force_fuse,
  input wire logic        flash_volt_level_fuse,
  input wire logic        pad_debug_disable_fuse,
  input wire logic        usb_debug_disable_fuse,
  input wire logic        debug_strap_enable_fuse,
  input wire slbc_boot_t  boot_mode_q,
  input wire slbc_volt_t  flash_volt_q,
  input wire slbc_dbg_t   debug_src_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic run = straps_released_q;
  wire logic pd = pad_debug_disable_fuse;
  wire logic ud = usb_debug_disable_fuse;

  a_pull_off: assert property (
    run |-> pull_up_en_n_q && pull_down_en_n_q)
    else $error("pulls on after release");
  a_pull_prior: assert property (
    $rose(run) |-> !$past(pull_up_en_n_q) && !$past(pull_down_en_n_q))
    else $error("pulls were off while sampling");
  a_frozen: assert property (
    run && $past(run) |-> $stable(boot_mode_q) && $stable(flash_volt_q)
      && $stable(debug_src_q))
    else $error("decode moved while released");
  a_run_chip: assert property (run |-> chip_en_q)
    else $error("released while chip off");
  a_sample_len: assert property ($rose(chip_en_q) |-> ##4 $rose(run))
    else $error("sample window length");
  a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  a_volt_force: assert property (
    run && flash_volt_force_fuse |-> flash_volt_q ==
      (flash_volt_level_fuse ? SLBC_VOLT_3V3 : SLBC_VOLT_1V8))
    else $error("forced voltage wrong");
  a_dbg_fuse: assert property (
    run && (pd || ud) |-> debug_src_q ==
      (!pd ? SLBC_DBG_PAD : !ud ? SLBC_DBG_USB : SLBC_DBG_OFF))
    else $error("debug source from fuses wrong");
  a_dbg_nosel: assert property (
    run && !pd && !ud && !debug_strap_enable_fuse |->
      debug_src_q == SLBC_DBG_USB)
    else $error("debug source without strap select");

  c_boot: cover property ($rose(run));
  c_off: cover property (run && debug_src_q == SLBC_DBG_OFF);
  c_dl: cover property (run && boot_mode_q == SLBC_BOOT_DOWNLOAD);
endmodule

bind slbc_top slbc_top_monitor #(.PU_CYC(PU_CYC)) u_mon (.*);
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for slbc_top with board model.
// Short power-down count; fuses change only while the chip is off.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import slbc_pkg::*;
  localparam int unsigned PU = 20;
  logic clk = 1'h0, rst = 1'h1, ce = 1'h1, power_up_pin = 1'h0;
  logic flash_volt_force_fuse, flash_volt_level_fuse, pad_debug_disable_fuse;
  logic usb_debug_disable_fuse, debug_strap_enable_fuse;
  logic uart_print_disable_fuse, usb_print_disable_fuse;
  logic [3:0] reg_addr = 4'h0, drv_val = 4'h0;
  logic [31:0] reg_wdata = 32'h0, rd_v;
  logic reg_wr = 1'h0, reg_rd = 1'h0, drv_en = 1'h0;
  logic [1:0] ctl = 2'h0;
  wire logic [31:0] reg_rdata;
  wire logic chip_en_q, straps_released_q, pull_up_en_n_q, pull_down_en_n_q;
  wire logic print_uart_en_q, print_usb_en_q, boot_strap_a_i;
  wire logic boot_print_strap_i, flash_volt_strap_i, debug_src_strap_i;
  wire slbc_boot_t boot_mode_q;
  wire slbc_volt_t flash_volt_q;
  wire slbc_dbg_t debug_src_q;
  int error_cnt = 0, total_checks = 0;

  slbc_top #(.PU_CYC(PU)) uut (.*);
  slbc_board board (.*);
  always #5 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic setf(input logic [6:0] f);
    {usb_print_disable_fuse, uart_print_disable_fuse, debug_strap_enable_fuse,
     usb_debug_disable_fuse, pad_debug_disable_fuse, flash_volt_level_fuse,
     flash_volt_force_fuse} <= f;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 rd_v = reg_rdata;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  // Power cycle with given straps and fuses, then judge the decode
  task automatic boot(input logic de, input logic [3:0] sv, input logic [6:0] f);
    logic [3:0] l;
    logic [1:0] bm, dg;
    logic vt;
    int n;
    power_up_pin <= 1'h0;
    repeat (PU + 10) @(posedge clk);
    chk("chip_en", chip_en_q, 1'h0);
    chk("pulls on", {pull_up_en_n_q, pull_down_en_n_q}, 2'h0);
    setf(f);
    drv_en <= de;
    drv_val <= sv;
    @(posedge clk);
    power_up_pin <= 1'h1;
    for (n = 0; n < 100 && straps_released_q !== 1'h1; n++)
      @(posedge clk);
    if (n == 100) begin
      error_cnt++;
      complete_run();
    end
    l = de ? sv : {sv[3], 3'h1};
    bm = l[0] ? 2'h0 : 2'h1;
    vt = f[0] ? ~f[1] : l[2];
    dg = (f[2] & f[3]) ? 2'h2 : f[2] ? 2'h0 : f[3] ? 2'h1 :
         (f[4] & ~l[3]) ? 2'h1 : 2'h0;
    rd(OFF_STATUS);
    chk("status", rd_v, {25'h0, dg, vt, bm, 2'h3});
    chk("boot port", boot_mode_q, bm);
    chk("volt port", flash_volt_q, vt);
    chk("debug port", debug_src_q, dg);
    rd(OFF_LATCH);
    chk("latch", rd_v, {28'h0, l});
    chk("print", {print_usb_en_q, print_uart_en_q}, 2'(~(f[6:5] | ctl)));
    drv_en <= 1'h1;
    drv_val <= ~l;
    repeat (3) @(posedge clk);
    rd(OFF_LATCH);
    chk("latch held", rd_v, {28'h0, l});
    chk("pulls", {pull_up_en_n_q, pull_down_en_n_q}, 2'h3);
    $display("boot case %h %h done", sv, f);
  endtask
  task automatic regs;
    logic [31:0] lv;
    rd(OFF_LATCH);
    lv = rd_v;
    wr(OFF_PRINT_CTL, 32'h1);
    ctl = 2'h1;
    wr(OFF_LATCH, 32'hF);
    rd(OFF_PRINT_CTL);
    chk("print ctl", rd_v, 32'h1);
    chk("print en", {print_usb_en_q, print_uart_en_q}, 2'h2);
    rd(4'h2);
    chk("unmapped", rd_v, 32'h0);
    rd(OFF_LATCH);
    chk("latch ro", rd_v, lv);
    $display("register case done");
  endtask

  initial begin
    setf(7'h00);
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    repeat (SETTLE_CYC) @(posedge clk);
    boot(1'h0, 4'h0, 7'h00);
    boot(1'h1, 4'h4, 7'h10);
    boot(1'h1, 4'hB, 7'h11);
    regs();
    boot(1'h1, 4'h0, 7'h27);
    boot(1'h1, 4'h8, 7'h48);
    boot(1'h1, 4'h1, 7'h0C);
    complete_run();
  end
endmodule
`default_nettype wire
